/* design/config_fuse_decoder_map.vh */
// Field positions and reset values for the configuration word decoder
`ifndef CONFIG_FUSE_DECODER_MAP_VH
`define CONFIG_FUSE_DECODER_MAP_VH
// APB byte offsets
`define REG_CTRL_OFS        12'h000
`define REG_LOAD_OFS        12'h004
`define REG_STATUS_OFS      12'h008
`define REG_OSC_OFS         12'h00C
`define REG_WDT_OFS         12'h010
`define REG_PINMAP_OFS      12'h014
// Secure segment word
`define SECURE_RAM_SIZE_LSB 1
// General segment word
`define GEN_WRITE_PROT_BIT  0
`define GEN_CODE_PROT_LSB   1
// Oscillator select word
`define INIT_OSC_LSB        0
`define TWO_SPEED_BIT       7
// Oscillator config word
`define PRIMARY_MODE_LSB    0
`define SEC_PIN_FUNC_BIT    2
`define PIN_MAP_LOCK_BIT    5
`define CLK_SWITCH_LSB      6
// Watchdog word
`define WDT_WINDOW_DIS_BIT  6
`define WDT_FORCE_EN_BIT    7
// Secure RAM byte sizes
`define SECURE_RAM_NONE     13'h0000
`define SECURE_RAM_SMALL    13'h0100
`define SECURE_RAM_MEDIUM   13'h0800
`define SECURE_RAM_LARGE    13'h1000
// Code protect levels
`define PROT_NONE           2'h0
`define PROT_STANDARD       2'h1
`define PROT_HIGH           2'h2
// Oscillator source one-hot codes
`define OSC_FAST_RC_POST    8'h80
`define OSC_FAST_RC_DIV16   8'h40
`define OSC_LOW_POWER_RC    8'h20
`define OSC_SECONDARY       8'h10
`define OSC_PRIMARY_PLL     8'h08
`define OSC_PRIMARY         8'h04
`define OSC_FAST_RC_PLL     8'h02
`define OSC_FAST_RC         8'h01
// Primary oscillator modes (one-hot)
`define PMODE_OFF           4'h8
`define PMODE_FAST_XTAL     4'h4
`define PMODE_STD_XTAL      4'h2
`define PMODE_EXT_CLK       4'h1
// Erased word value
`define CFG_WORD_RESET      8'hFF
`endif

/* design/config_fuse_decoder.v */
// Configuration word decoder with APB status and run-time update port
//
// What this block does
// RULE_01: Secure RAM size field decodes to four sizes
// RULE_02: Code protect field: none, standard, high
// RULE_03: Write protect bit zero blocks program writes
// RULE_04: Two-speed bit starts on fast RC first
// RULE_05: Initial oscillator field decodes eight sources
// RULE_06: Oscillator update waits reset if switching enabled; the reset clears the pending update instead
// RULE_07: Switch mode field gates switching and monitor
// RULE_08: Pin map lock allows one reconfiguration
// RULE_09: Secondary pin clock-out or GPIO outside crystal
// RULE_10: Primary mode field: off, two crystals, external
// RULE_11: Watchdog force bit keeps watchdog always running
// RULE_12: Window bit zero selects watchdog window mode
// RULE_13: Fields held from reset; immediate fields excepted; the code decodes live words unless rt_ctrl_en_q selects the held words
`timescale 1ns/1ps
`include "config_fuse_decoder_map.vh"

module config_fuse_decoder (
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_rst_n,
   // Stored configuration words (quasi-static, from non-volatile array)
   input  wire [7:0]  i_secure_segment_config_word,
   input  wire [7:0]  i_general_segment_config_word,
   input  wire [7:0]  i_oscillator_select_config_word,
   input  wire [7:0]  i_oscillator_config_word,
   input  wire [7:0]  i_watchdog_config_word,
   // Clock logic feedback
   input  wire        i_user_osc_ready,
   input  wire        i_software_watchdog_enable,
   input  wire        i_crystal_osc_clock,
   input  wire        i_pin_map_write_req,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Memory protection outputs
   output reg  [12:0] o_secure_ram_size,
   output reg  [1:0]  o_general_code_protect_level,
   output reg         o_program_write_block,
   // Clock outputs
   output reg  [7:0]  o_active_osc_source,
   output reg  [7:0]  o_initial_oscillator_source,
   output reg         o_clock_switch_enable,
   output reg         o_fail_safe_monitor_enable,
   output reg  [3:0]  o_primary_oscillator_mode,
   output reg         o_secondary_pin_clock_out,
   output reg         o_secondary_pin_gpio,
   // Pin map and watchdog outputs
   output reg         o_pin_map_write_allow,
   output reg         o_watchdog_run,
   output reg         o_watchdog_osc_on,
   output reg         o_watchdog_window_mode
);

   // Reset synchroniser
   reg        rst_s1_q;                  // First stage, read by second only
   reg        rst_s2_q;                  // Synchronised reset, active low
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Input synchronisers for the outside-domain levels
   reg  [43:0] in_s1_q;                  // First stage
   reg  [43:0] in_s2_q;                  // Second stage, used by logic
   wire [43:0] in_raw = {i_secure_segment_config_word, i_general_segment_config_word,
                         i_oscillator_select_config_word, i_oscillator_config_word,
                         i_watchdog_config_word, i_user_osc_ready,
                         i_software_watchdog_enable, i_crystal_osc_clock, i_pin_map_write_req};
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         in_s1_q <= 44'h00000000000;
         in_s2_q <= 44'h00000000000;
      end else begin
         in_s1_q <= in_raw;
         in_s2_q <= in_s1_q;
      end
   end
   wire [7:0] ss_w  = in_s2_q[43:36];   // Secure segment word
   wire [7:0] gs_w  = in_s2_q[35:28];   // General segment word
   wire [7:0] os_w  = in_s2_q[27:20];   // Oscillator select word
   wire [7:0] oc_w  = in_s2_q[19:12];   // Oscillator config word
   wire [7:0] wd_w  = in_s2_q[11:4];    // Watchdog word
   wire       osc_rdy  = in_s2_q[3];
   wire       sw_wdt   = in_s2_q[2];
   wire       xtal_clk = in_s2_q[1];
   wire       pm_req   = in_s2_q[0];

   // Capture sequencer: one-hot
   localparam [2:0] ST_WAIT = 3'h1;     // Synchronisers filling
   localparam [2:0] ST_LOAD = 3'h2;     // Latch words into holding
   localparam [2:0] ST_RUN  = 3'h4;     // Normal operation
   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg  [1:0] wait_q;                   // Settling count
   always @* begin
      case (state_q)
         ST_WAIT: state_d = (wait_q == 2'h3) ? ST_LOAD : ST_WAIT;
         ST_LOAD: state_d = ST_RUN;
         ST_RUN:  state_d = ST_RUN;
         default: state_d = ST_WAIT;
      endcase
   end
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         state_q <= ST_WAIT;
         wait_q  <= 2'h0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_WAIT)
            wait_q <= wait_q + 2'h1;
      end
   end
   wire load = (state_q == ST_LOAD);
   wire run  = (state_q == ST_RUN);

   // APB registers: run-time update request and held-word select
   reg  [7:0] rt_osc_sel_q;             // Software-written oscillator select word
   reg        rt_pend_q;                // Update request waiting
   reg        rt_ctrl_en_q;             // Use held words instead of live words
   wire       acc    = psel & penable;
   wire       wr     = acc & pwrite;
   wire       hit    = (paddr == `REG_CTRL_OFS) | (paddr == `REG_LOAD_OFS) |
                       (paddr == `REG_STATUS_OFS) | (paddr == `REG_OSC_OFS) |
                       (paddr == `REG_WDT_OFS) | (paddr == `REG_PINMAP_OFS);
   assign pready  = 1'b1;                // Zero wait states
   assign pslverr = acc & ~hit;          // Unmapped access flagged
   wire   wr_osc  = wr & (paddr == `REG_OSC_OFS);

   // Holding registers, captured at load time
   reg  [7:0] ss_q;
   reg  [7:0] gs_q;
   reg  [7:0] os_q;                      // Oscillator select in effect
   reg  [7:0] oc_q;
   reg  [7:0] wd_q;
   // Switching enable taken from the held word so it cannot move at run time
   wire       sw_en_held = ~oc_q[`CLK_SWITCH_LSB+1];
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         ss_q <= `CFG_WORD_RESET;
         gs_q <= `CFG_WORD_RESET;
         os_q <= `CFG_WORD_RESET;
         oc_q <= `CFG_WORD_RESET;
         wd_q <= `CFG_WORD_RESET;
      end else if (load) begin
         ss_q <= ss_w;                   // RULE_13
         gs_q <= gs_w;                   // RULE_13
         oc_q <= oc_w;                   // RULE_13
         wd_q <= wd_w;                   // RULE_13
         // A software word still pending at load replaces the stored word
         os_q <= rt_pend_q ? rt_osc_sel_q : os_w;   // RULE_06
      end else if (run && rt_pend_q && !sw_en_held) begin
         os_q <= rt_osc_sel_q;           // RULE_06
      end
   end

   // Software update register; request is cleared at load, or in run when switching is disabled
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         rt_osc_sel_q <= `CFG_WORD_RESET;
         rt_pend_q    <= 1'b0;
         rt_ctrl_en_q <= 1'b0;
      end else begin
         if (wr_osc) begin
            rt_osc_sel_q <= pwdata[7:0];
            rt_pend_q    <= 1'b1;
         end else if (load || (run && !sw_en_held)) begin
            rt_pend_q    <= 1'b0;        // Consumed
         end
         if (wr && paddr == `REG_CTRL_OFS)
            rt_ctrl_en_q <= pwdata[0];
      end
   end

   // Fields read live words unless rt_ctrl_en_q selects holding registers; osel always reads os_q
   wire [7:0] ss_eff = rt_ctrl_en_q ? ss_q : ss_w;
   wire [7:0] gs_eff = rt_ctrl_en_q ? gs_q : gs_w;
   wire [7:0] oc_eff = rt_ctrl_en_q ? oc_q : oc_w;
   wire [7:0] wd_eff = rt_ctrl_en_q ? wd_q : wd_w;
   wire [1:0] ram_code  = ss_eff[`SECURE_RAM_SIZE_LSB+1:`SECURE_RAM_SIZE_LSB];
   wire [1:0] prot_code = gs_eff[`GEN_CODE_PROT_LSB+1:`GEN_CODE_PROT_LSB];
   wire [2:0] osel = os_q[`INIT_OSC_LSB+2:`INIT_OSC_LSB];
   wire [1:0] cks  = oc_eff[`CLK_SWITCH_LSB+1:`CLK_SWITCH_LSB];
   wire [1:0] pmd  = oc_eff[`PRIMARY_MODE_LSB+1:`PRIMARY_MODE_LSB];

   // Decoders
   reg  [12:0] ram_d;
   reg  [1:0]  prot_d;
   reg  [7:0]  osc_d;
   reg  [3:0]  pmode_d;
   always @* begin
      case (ram_code)                    // RULE_01
         2'h3:    ram_d = `SECURE_RAM_NONE;
         2'h2:    ram_d = `SECURE_RAM_SMALL;
         2'h1:    ram_d = `SECURE_RAM_MEDIUM;
         default: ram_d = `SECURE_RAM_LARGE;
      endcase
      case (prot_code)                   // RULE_02
         2'h3:    prot_d = `PROT_NONE;
         2'h2:    prot_d = `PROT_STANDARD;
         default: prot_d = `PROT_HIGH;
      endcase
      case (osel)                        // RULE_05
         3'h7:    osc_d = `OSC_FAST_RC_POST;
         3'h6:    osc_d = `OSC_FAST_RC_DIV16;
         3'h5:    osc_d = `OSC_LOW_POWER_RC;
         3'h4:    osc_d = `OSC_SECONDARY;
         3'h3:    osc_d = `OSC_PRIMARY_PLL;
         3'h2:    osc_d = `OSC_PRIMARY;
         3'h1:    osc_d = `OSC_FAST_RC_PLL;
         default: osc_d = `OSC_FAST_RC;
      endcase
      case (pmd)                         // RULE_10
         2'h3:    pmode_d = `PMODE_OFF;
         2'h2:    pmode_d = `PMODE_FAST_XTAL;
         2'h1:    pmode_d = `PMODE_STD_XTAL;
         default: pmode_d = `PMODE_EXT_CLK;
      endcase
   end

   // Two-speed start: hold fast RC until the chosen source reports ready
   reg  startup_done_q;
   wire two_speed = os_q[`TWO_SPEED_BIT];
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q)
         startup_done_q <= 1'b0;
      else if (run && (!two_speed || osc_rdy))
         startup_done_q <= 1'b1;         // RULE_04
   end

   // Pin map: lock permits only the first write after reset
   reg  pin_map_used_q;
   wire pin_map_lock = oc_eff[`PIN_MAP_LOCK_BIT];
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q)
         pin_map_used_q <= 1'b0;
      else if (run && pm_req && o_pin_map_write_allow)
         pin_map_used_q <= 1'b1;         // RULE_08
   end

   // Registered outputs; all quiet until the first capture
   wire crystal = (pmd == 2'h2) | (pmd == 2'h1);
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         o_secure_ram_size            <= `SECURE_RAM_NONE;
         o_general_code_protect_level <= `PROT_HIGH;
         o_program_write_block        <= 1'b1;
         o_active_osc_source          <= `OSC_FAST_RC;
         o_initial_oscillator_source  <= `OSC_FAST_RC;
         o_clock_switch_enable        <= 1'b0;
         o_fail_safe_monitor_enable   <= 1'b0;
         o_primary_oscillator_mode    <= `PMODE_OFF;
         o_secondary_pin_clock_out    <= 1'b0;
         o_secondary_pin_gpio         <= 1'b0;
         o_pin_map_write_allow        <= 1'b0;
         o_watchdog_run               <= 1'b0;
         o_watchdog_osc_on            <= 1'b0;
         o_watchdog_window_mode       <= 1'b0;
      end else if (run) begin
         o_secure_ram_size            <= ram_d;                              // RULE_01
         o_general_code_protect_level <= prot_d;                             // RULE_02
         o_program_write_block        <= ~gs_eff[`GEN_WRITE_PROT_BIT];       // RULE_03
         o_active_osc_source          <= (two_speed && !startup_done_q) ? `OSC_FAST_RC : osc_d; // RULE_04
         o_initial_oscillator_source  <= osc_d;                              // RULE_05
         o_clock_switch_enable        <= ~cks[1];                            // RULE_07
         o_fail_safe_monitor_enable   <= (cks == 2'h0);                      // RULE_07
         o_primary_oscillator_mode    <= pmode_d;                            // RULE_10
         // Crystal modes own the pin regardless of the function bit
         o_secondary_pin_clock_out    <= ~crystal & oc_eff[`SEC_PIN_FUNC_BIT];  // RULE_09
         o_secondary_pin_gpio         <= ~crystal & ~oc_eff[`SEC_PIN_FUNC_BIT]; // RULE_09
         o_pin_map_write_allow        <= ~pin_map_lock | ~pin_map_used_q;    // RULE_08
         o_watchdog_run               <= wd_eff[`WDT_FORCE_EN_BIT] | sw_wdt; // RULE_11
         o_watchdog_osc_on            <= wd_eff[`WDT_FORCE_EN_BIT] | sw_wdt; // RULE_11
         o_watchdog_window_mode       <= ~wd_eff[`WDT_WINDOW_DIS_BIT];       // RULE_12
      end
   end

   // Read mux; registered so data comes from flip-flops
   always @(posedge i_core_clk or negedge rst_s2_q) begin
      if (!rst_s2_q)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite) begin
         case (paddr)
            `REG_CTRL_OFS:   prdata <= {31'h00000000, rt_ctrl_en_q};
            `REG_LOAD_OFS:   prdata <= {24'h000000, rt_osc_sel_q};
            `REG_STATUS_OFS: prdata <= {26'h0000000, xtal_clk, pin_map_used_q, startup_done_q,
                                        rt_pend_q, state_q[2], sw_en_held};
            `REG_OSC_OFS:    prdata <= {16'h0000, o_active_osc_source, o_initial_oscillator_source};
            `REG_WDT_OFS:    prdata <= {29'h00000000, o_watchdog_window_mode, o_watchdog_osc_on,
                                        o_watchdog_run};
            `REG_PINMAP_OFS: prdata <= {30'h00000000, pin_map_used_q, o_pin_map_write_allow};
            default:         prdata <= 32'h00000000;
         endcase
      end
   end

endmodule // config_fuse_decoder

/* bench/config_fuse_decoder_monitor.sv */
// Port checker for the configuration word decoder
`timescale 1ns/1ps
module config_fuse_decoder_monitor (
   // Clock and reset
   input logic        i_core_clk,
   input logic        i_rst_n,
   // Configuration words
   input logic [7:0]  i_secure_segment_config_word,
   input logic [7:0]  i_general_segment_config_word,
   input logic [7:0]  i_oscillator_config_word,
   input logic [7:0]  i_watchdog_config_word,
   input logic        i_pin_map_write_req,
   // APB
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   // Decoded outputs
   input logic [12:0] o_secure_ram_size,
   input logic [1:0]  o_general_code_protect_level,
   input logic        o_program_write_block,
   input logic        o_clock_switch_enable,
   input logic        o_fail_safe_monitor_enable,
   input logic [3:0]  o_primary_oscillator_mode,
   input logic        o_secondary_pin_clock_out,
   input logic        o_secondary_pin_gpio,
   input logic        o_pin_map_write_allow,
   input logic        o_watchdog_run,
   input logic        o_watchdog_window_mode
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   wire [7:0]   sec = i_secure_segment_config_word;  // Short aliases
   wire [7:0]   gen = i_general_segment_config_word;
   wire [7:0]   oc  = i_oscillator_config_word;
   wire [7:0]   wd  = i_watchdog_config_word;
   logic [4:0]  up_q;    // Cycles since reset release, saturating
   logic [2:0]  st_q;    // Cycles the words have stood still
   logic [31:0] last_q;  // Words seen one cycle ago
   logic        held_q;  // Held-word mode, snooped from the bus
   // Judge live decode once load is done and the words have outlasted the sync delay
   wire         ok = up_q > 5'h0B && st_q > 3'h2 && last_q == {sec, gen, oc, wd} && !held_q;
   // Settling counters
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up_q <= 5'h00;
         st_q <= 3'h0;
         last_q <= 32'h0;
         held_q <= 1'b0;
      end else begin
         up_q <= (up_q == 5'h1F) ? up_q : up_q + 5'h01;
         last_q <= {sec, gen, oc, wd};
         st_q <= (last_q != {sec, gen, oc, wd}) ? 3'h0 : ((st_q == 3'h7) ? st_q : st_q + 3'h1);
         if (psel && penable && pwrite && paddr == 12'h000) held_q <= pwdata[0];
      end
   end
   // A granted write attempt while the lock is set
   sequence s_lock_use;
      ok && oc[5] && o_pin_map_write_allow && i_pin_map_write_req;
   endsequence
   a_ram_size_decode : assert property (
      ok |-> o_secure_ram_size == (sec[2:1] == 2'b11 ? 13'h0000 : sec[2:1] == 2'b10 ? 13'h0100 :
                                   sec[2:1] == 2'b01 ? 13'h0800 : 13'h1000)) else $error("secure ram size");
   a_protect_level : assert property (
      ok |-> o_general_code_protect_level == (gen[2] ? (gen[1] ? 2'h0 : 2'h1) : 2'h2)) else $error("protect level");
   a_write_block : assert property (ok |-> o_program_write_block == !gen[0]) else $error("write block");
   a_switch_monitor : assert property (
      ok |-> o_clock_switch_enable == !oc[7] && o_fail_safe_monitor_enable == (oc[7:6] == 2'b00))
      else $error("switch mode");
   a_primary_mode : assert property (
      ok |-> o_primary_oscillator_mode == (4'h1 << oc[1:0])) else $error("primary mode");
   a_sec_pin_func : assert property (
      ok && oc[1] == oc[0] |-> o_secondary_pin_clock_out == oc[2] && o_secondary_pin_gpio == !oc[2])
      else $error("secondary pin");
   a_watchdog_force : assert property (ok && wd[7] |-> o_watchdog_run) else $error("watchdog force");
   a_window_mode : assert property (ok |-> o_watchdog_window_mode == !wd[6]) else $error("window mode");
   a_pin_map_lock : assert property (
      s_lock_use |-> ##[1:4] !o_pin_map_write_allow) else $error("pin map lock");
endmodule // config_fuse_decoder_monitor
bind config_fuse_decoder config_fuse_decoder_monitor mon_u (.*);

/* bench/testbench.sv */
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps
module testbench;
   logic        clk, rst_n, rdy, sw, pmreq, psel, penable, pwrite, chk_req;
   logic [7:0]  sec, gen, osw, oc, wd;  // Stored configuration words
   logic [11:0] paddr;
   logic [31:0] pwdata, r;
   logic [2:0]  osc_now;                // Oscillator code that should be in force
   wire         pready, pslverr, cs, fm, co, gp, al, wr, wl, wm, wb;
   wire  [31:0] prdata;
   wire  [12:0] rs;
   wire  [1:0]  pl;
   wire  [7:0]  act, ini;
   wire  [3:0]  pm;
   wire  [43:0] obs = {act, al, wr, wl, rs, pl, wb, ini, cs, fm, pm, co, gp, wm};
   logic [32:0] rdq[$];                 // Expected reads: error flag and data
   logic [87:0] dq[$];                  // Expected outputs: mask then value
   logic [87:0] nt;
   logic [32:0] rn;
   logic [43:0] e_hold;                 // Expected outputs while held mode is on
   int          err_count, compares;
   localparam logic [43:0] ALL = {44{1'b1}};
   localparam logic [43:0] NOACT = {8'h00, {36{1'b1}}};  // Active source left out
   localparam logic [43:0] SAFE = {8'h01, 3'b000, 13'h0000, 2'h2, 1'b1, 8'h01, 2'b00, 4'h8, 3'b000};
   config_fuse_decoder dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_secure_segment_config_word(sec),
      .i_general_segment_config_word(gen), .i_oscillator_select_config_word(osw),
      .i_oscillator_config_word(oc), .i_watchdog_config_word(wd), .i_user_osc_ready(rdy),
      .i_software_watchdog_enable(sw), .i_crystal_osc_clock(1'b0), .i_pin_map_write_req(pmreq),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .o_secure_ram_size(rs), .o_general_code_protect_level(pl),
      .o_program_write_block(wb), .o_active_osc_source(act), .o_initial_oscillator_source(ini),
      .o_clock_switch_enable(cs), .o_fail_safe_monitor_enable(fm), .o_primary_oscillator_mode(pm),
      .o_secondary_pin_clock_out(co), .o_secondary_pin_gpio(gp), .o_pin_map_write_allow(al),
      .o_watchdog_run(wr), .o_watchdog_osc_on(wl), .o_watchdog_window_mode(wm));
   // 25 MHz core clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Expected outputs worked out from the stored words
   function automatic logic [43:0] ev(input logic [7:0] a, input logic allow);
      logic [12:0] s;
      logic        x;
      s = sec[2:1] == 2'b11 ? 13'h0000 : sec[2:1] == 2'b10 ? 13'h0100 : sec[2:1] == 2'b01 ? 13'h0800 : 13'h1000;
      x = oc[1] ^ oc[0];  // Crystal modes own the secondary pin
      return {a, allow, wd[7] | sw, wd[7] | sw, s, gen[2] ? (gen[1] ? 2'h0 : 2'h1) : 2'h2, !gen[0],
              8'h01 << osc_now, !oc[7], oc[7:6] == 2'b00, 4'h1 << oc[1:0], oc[2] && !x, !oc[2] && !x, !wd[6]};
   endfunction
   task err(input string m);
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task finish_test;
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Note an expected output set; the watcher compares it at the next edge
   task chk(input logic [43:0] e, input logic [43:0] m);
      dq.push_back({m, e});
      chk_req <= 1'b1;
      @(posedge clk);
      chk_req <= 1'b0;
      @(posedge clk);
   endtask
   // One APB transfer; ready is awaited under a bound
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) rdq.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!pready && n < 50);
      if (!pready) err("no ready");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Reset with a look at the safe values while it is held
   task do_reset;
      rst_n <= 1'b0;
      cyc(5);
      chk(SAFE, ALL);
      cyc(5);
      rst_n <= 1'b1;
      cyc(20);
   endtask
   // Watcher: takes the oldest note whenever a result appears
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         compares++;
         rn = rdq.pop_front();
         if ({pslverr, prdata} !== rn) err("read answer");
      end
      if (chk_req) begin
         compares++;
         nt = dq.pop_front();
         if ((obs & nt[87:44]) !== (nt[43:0] & nt[87:44])) err("decoded outputs");
      end
   end
   // Hang guard
   initial begin
      cyc(20000);
      err("timeout");
      finish_test;
   end
   // Main sequence
   initial begin
      {rst_n, pmreq, psel, penable, pwrite, chk_req, sw} = 7'h00;
      {sec, gen, osw, oc, wd} = {40{1'b1}};
      {paddr, pwdata} = 44'h0;
      rdy = 1'b1;
      osc_now = 3'h7;
      r = $urandom(53);
      do_reset;
      chk(ev(8'h80, 1'b1), ALL);
      // Every field code of the secure, general, oscillator config and watchdog words, with random filler in the other bits
      for (int i = 0; i < 16; i++) begin
         r = $urandom;
         sec <= {r[7:3], i[1:0], r[0]};
         gen <= {r[15:11], i[1:0], i[2]};
         oc <= {i[3:2], r[21:19], i[2], i[1:0]};
         wd <= {i[1:0], r[29:24]};
         sw <= r[30];
         cyc(6);
         chk(ev(8'h80, 1'b1), ALL);
      end
      // Switching disabled: software oscillator code applies at once
      oc <= 8'hFF;
      do_reset;
      for (int v = 0; v < 8; v++) begin
         apb(1'b1, 12'h00C, v, 33'h0);
         cyc(2);
         osc_now = v[2:0];
         chk(ev(8'h00, 1'b1), NOACT);
      end
      // Switching enabled: the new code stays pending and is not applied
      oc <= 8'h3F;
      osw <= 8'h02;
      osc_now = 3'h2;
      do_reset;
      apb(1'b1, 12'h00C, 32'h5, 33'h0);
      cyc(3);
      chk(ev(8'h00, 1'b1), NOACT);
      apb(1'b0, 12'h008, 32'h0, 33'h0000000F);
      apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
      apb(1'b0, 12'h000, 32'h0, 33'h0);
      // Two-speed start: fast RC until the chosen source is ready
      rdy <= 1'b0;
      osw <= 8'h83;
      osc_now = 3'h3;
      do_reset;
      chk(ev(8'h01, 1'b1), ALL);
      rdy <= 1'b1;
      cyc(6);
      chk(ev(8'h08, 1'b1), ALL);
      rdy <= 1'b0;
      osw <= 8'h03;
      do_reset;
      chk(ev(8'h08, 1'b1), ALL);
      // Pin map lock: one change only, then free again without the lock
      rdy <= 1'b1;
      oc <= 8'hFF;
      do_reset;
      pmreq <= 1'b1;
      cyc(1);
      pmreq <= 1'b0;
      cyc(4);
      chk(ev(8'h08, 1'b0), ALL);
      oc <= 8'hDF;
      cyc(6);
      chk(ev(8'h08, 1'b1), ALL);
      // Held mode: live word changes must not reach the outputs
      e_hold = ev(8'h08, 1'b0);  // Held word still has the lock set, and it was used
      apb(1'b1, 12'h000, 32'h1, 33'h0);
      {sec, gen, wd} <= ~{sec, gen, wd};
      cyc(6);
      chk(e_hold, ALL);
      apb(1'b0, 12'h000, 32'h0, 33'h1);
      finish_test;
   end
endmodule // testbench
